//--- fgo_top.sv
// Field counted general purpose output generator with APB register slave.
//
// Contract
// - Field counter advances once per vertical sync.
// - Action zero starts nothing; a running or waiting count goes on.
// - Action one counts once then idles.
// - Action two wraps and repeats.
// - Action three waits delay plus one fields first.
// - Action seven forces idle; four-six reserved.
// - Four bit counter maximum value.
// - Four bit delay field count.
// - Two bit protocol per signal.
// - Every line mode ignores line position.
// - Start polarity applied only in manual.
// - Pin enable drives pin, else high impedance; pin two is always released under external blanking.
// - Fast select picks one of four clocks.
// - External blanking taken from pin two.
// - Four bit lookup code defines combination.
// - Lookup result routable per pin.
// - Toggle positions: field, line, pixel.
// - Two signals, two toggles each.
// - Action field self clears each vertical sync.
// - Manual toggles start next field, repeat.
// - Lookup index is signal two, signal one.
`timescale 1ns/1ns
module fgo_top (
  input  wire logic        core_clk_i,      // Pixel clock, 125 MHz.
  input  wire logic        rst_i,           // Asynchronous reset, active high.
  input  wire logic        psel_i,          // APB select.
  input  wire logic        penable_i,       // APB enable.
  input  wire logic        pwrite_i,        // APB write.
  input  wire logic [11:0] paddr_i,         // APB byte address.
  input  wire logic [31:0] pwdata_i,        // APB write data.
  output logic             pready_o,        // APB ready.
  output logic      [31:0] prdata_o,        // APB read data.
  output logic             pslverr_o,       // APB error outside indices 0x50 to 0x5a or on an unaligned address.
  input  wire logic        vertical_sync_i, // Field start strobe, one cycle.
  input  wire logic        hsync_i,         // Line start strobe, one cycle.
  input  wire logic        black_clamp_pulse_i, // Clamp timing.
  input  wire logic        preblank_pulse_i,    // Preblank timing.
  input  wire logic [3:0]  fast_timing_i,   // Delayed clocks: input, latch, data, ref.
  input  wire logic        horizontal_blanking_int_i, // Internal blanking.
  input  wire logic [1:0]  gp_pin_in_i,     // Pin input levels.
  output logic      [1:0]  gp_pin_out_o,    // Pin output levels.
  output logic      [1:0]  gp_pin_oe_n_o,   // Pin output enable, low drives.
  output logic             horizontal_blanking_o // Selected blanking.
);
  logic [12:0] line_q;
  logic [12:0] pixel_q;
  logic [2:0]  action_q;
  logic [3:0]  max_q;
  logic [3:0]  delay_q;
  logic [31:0] proto_q;
  logic [31:0] pins_q;
  fgo_pkg::fgo_toggle_s tog_q [fgo_pkg::NUM_TOG];
  logic [3:0]  count_q;
  logic [3:0]  wait_q;
  logic        running_q;
  logic        repeat_q;
  logic        waiting_q;
  logic [1:0]  gp_q;
  logic [1:0]  arm_q;
  logic [1:0]  prev_idle_q;

  logic        access;
  logic [9:0]  idx;
  logic        mapped;
  logic [31:0] rd;

  function automatic logic [1:0] proto_of(input logic [31:0] p, input int s);
    proto_of = p[fgo_pkg::PROTO_LSB+2*s +: 2];
  endfunction

  // Registers answer in the first access cycle, so pready is a constant high.
  assign pready_o = 1'b1;
  assign access   = psel_i & penable_i;
  assign idx      = paddr_i[11:2];
  assign mapped   = (idx >= {2'b00, fgo_pkg::IDX_ACTION}) &&
                    (idx <= {2'b00, fgo_pkg::IDX_STATUS}) && (paddr_i[1:0] == 2'b00);
  assign pslverr_o = access & ~mapped;

  always_comb begin
    rd = 32'h0000_0000;
    if (idx == {2'b00, fgo_pkg::IDX_ACTION}) begin
      rd = {29'h0000_0000, action_q};
    end else if (idx == {2'b00, fgo_pkg::IDX_LIMITS}) begin
      rd = {24'h00_0000, delay_q, max_q};
    end else if (idx == {2'b00, fgo_pkg::IDX_PROTO}) begin
      rd = proto_q;
    end else if (idx == {2'b00, fgo_pkg::IDX_PINS}) begin
      rd = pins_q;
    end else if (idx == {2'b00, fgo_pkg::IDX_STATUS}) begin
      rd = {22'h00_0000, gp_q, running_q, waiting_q, count_q, 2'b00};
    end else begin
      for (int i = 0; i < fgo_pkg::NUM_TOG; i++) begin
        if (idx == 10'(fgo_pkg::IDX_TOG0) + 10'(i)) begin
          rd = {2'b00, tog_q[i]};
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_o <= rd;
    end
  end

  // Line and pixel position within the field.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_q  <= 13'h0000;
      pixel_q <= 13'h0000;
    end else if (vertical_sync_i) begin
      line_q  <= 13'h0000;
      pixel_q <= 13'h0000;
    end else if (hsync_i) begin
      line_q  <= line_q + 13'h0001;
      pixel_q <= 13'h0000;
    end else begin
      pixel_q <= pixel_q + 13'h0001;
    end
  end

  // Configuration registers.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      max_q   <= 4'h0;
      delay_q <= 4'h0;
      proto_q <= {18'h0_0000, fgo_pkg::RESET_LUT, 10'h000};
      pins_q  <= fgo_pkg::RESET_WORD;
      for (int i = 0; i < fgo_pkg::NUM_TOG; i++) begin
        tog_q[i] <= '0;
      end
    end else if (access & pwrite_i) begin
      if (idx == {2'b00, fgo_pkg::IDX_LIMITS}) begin
        max_q   <= pwdata_i[fgo_pkg::MAX_LSB +: 4];
        delay_q <= pwdata_i[fgo_pkg::DELAY_LSB +: 4];
      end
      if (idx == {2'b00, fgo_pkg::IDX_PROTO}) begin
        proto_q <= {18'h0_0000, pwdata_i[13:0]};
      end
      if (idx == {2'b00, fgo_pkg::IDX_PINS}) begin
        pins_q <= {21'h00_0000, pwdata_i[10:0]};
      end
      for (int i = 0; i < fgo_pkg::NUM_TOG; i++) begin
        if (idx == 10'(fgo_pkg::IDX_TOG0) + 10'(i)) begin
          tog_q[i] <= pwdata_i[29:0];
        end
      end
    end
  end

  // Action field: written by software, cleared at every field start; the clear wins.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      action_q <= 3'b000;
    end else if (vertical_sync_i) begin
      action_q <= 3'b000;
    end else if (access & pwrite_i & (idx == {2'b00, fgo_pkg::IDX_ACTION})) begin
      action_q <= pwdata_i[2:0];
    end
  end

  // Primary field counter; acts on the action latched in the previous field.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q   <= 4'h0;
      wait_q    <= 4'h0;
      running_q <= 1'b0;
      repeat_q  <= 1'b0;
      waiting_q <= 1'b0;
    end else if (vertical_sync_i) begin
      case (action_q)
        fgo_pkg::ACT_SINGLE, fgo_pkg::ACT_REPEAT: begin
          running_q <= 1'b1;
          repeat_q  <= (action_q == fgo_pkg::ACT_REPEAT);
          waiting_q <= 1'b0;
          count_q   <= 4'h1;
        end
        fgo_pkg::ACT_DELAY: begin
          waiting_q <= 1'b1;
          running_q <= 1'b0;
          repeat_q  <= 1'b0;
          wait_q    <= delay_q;
          count_q   <= 4'h0;
        end
        fgo_pkg::ACT_FORCE: begin
          running_q <= 1'b0;
          waiting_q <= 1'b0;
          repeat_q  <= 1'b0;
          count_q   <= 4'h0;
        end
        default: begin
          // Idle or reserved test codes let the counter go on: a wait counts down, a run steps, wraps or ends.
          if (waiting_q) begin
            if (wait_q == 4'h0) begin
              waiting_q <= 1'b0;
              running_q <= 1'b1;
              count_q   <= 4'h1;
            end else begin
              wait_q <= wait_q - 4'h1;
            end
          end else if (running_q) begin
            if (count_q >= max_q) begin
              count_q   <= repeat_q ? 4'h1 : 4'h0;
              running_q <= repeat_q;
            end else begin
              count_q <= count_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Each non-idle protocol arms at the next field; idle must have been seen first.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arm_q       <= 2'b00;
      prev_idle_q <= 2'b11;
    end else if (vertical_sync_i) begin
      for (int s = 0; s < 2; s++) begin
        arm_q[s]       <= (proto_of(proto_q, s) != fgo_pkg::PR_IDLE) &
                          (prev_idle_q[s] | arm_q[s]);
        prev_idle_q[s] <= (proto_of(proto_q, s) == fgo_pkg::PR_IDLE);
      end
    end
  end

  // General purpose signals.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gp_q <= 2'b00;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (proto_of(proto_q, s) == fgo_pkg::PR_IDLE) begin
          gp_q[s] <= gp_q[s];
        end else if (vertical_sync_i & (proto_of(proto_q, s) == fgo_pkg::PR_MANUAL)) begin
          gp_q[s] <= proto_q[fgo_pkg::POL_LSB+s];
        end else if (arm_q[s]) begin
          for (int t = 0; t < 2; t++) begin
            if ((pixel_q == tog_q[2*s+t].pixel) &&
                (proto_q[fgo_pkg::LINE_LSB+s] || (line_q == tog_q[2*s+t].line)) &&
                ((proto_of(proto_q, s) == fgo_pkg::PR_MANUAL) ||
                 (running_q && (count_q == tog_q[2*s+t].field) &&
                  (repeat_q ? (proto_of(proto_q, s) == fgo_pkg::PR_REPEAT) : 1'b1)))) begin
              gp_q[s] <= ~gp_q[s];
            end
          end
        end
      end
    end
  end

  // Pin output multiplexing; pin two can become the blanking input.
  logic [1:0] lut_bit;
  assign lut_bit = {2{proto_q[fgo_pkg::LUT_LSB + {30'h0, gp_q}]}};

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gp_pin_out_o  <= 2'b00;
      gp_pin_oe_n_o <= 2'b11;
      horizontal_blanking_o <= 1'b0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        case (pins_q[fgo_pkg::SRC_LSB+2*p +: 2])
          2'b00: gp_pin_out_o[p] <= proto_q[fgo_pkg::LUTEN_LSB+p] ? lut_bit[p] : gp_q[p];
          2'b01: gp_pin_out_o[p] <= black_clamp_pulse_i;
          2'b10: gp_pin_out_o[p] <= preblank_pulse_i;
          default: gp_pin_out_o[p] <= fast_timing_i[pins_q[fgo_pkg::HS_LSB+2*p +: 2]];
        endcase
        gp_pin_oe_n_o[p] <= ~pins_q[fgo_pkg::OE_LSB+p];
      end
      if (pins_q[fgo_pkg::EXTBLK_LSB]) begin
        gp_pin_oe_n_o[1]      <= 1'b1;
        horizontal_blanking_o <= gp_pin_in_i[1];
      end else begin
        horizontal_blanking_o <= horizontal_blanking_int_i;
      end
    end
  end

  // Checks.
  a_action_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
    vertical_sync_i |=> (action_q == 3'b000)) else $error("action not cleared");
  a_force_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (vertical_sync_i && action_q == 3'b111) |=> !running_q && count_q == 4'h0)
    else $error("force idle failed");
  a_single_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (vertical_sync_i && action_q == 3'b001) |=> running_q && !repeat_q && count_q == 4'h1)
    else $error("single start wrong");
  a_repeat_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (vertical_sync_i && action_q == 3'b000 && running_q && repeat_q && !waiting_q
     && count_q >= max_q) |=> running_q && count_q == 4'h1) else $error("no wrap");
  a_single_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (vertical_sync_i && action_q == 3'b000 && running_q && !repeat_q && !waiting_q
     && count_q >= max_q) |=> !running_q) else $error("single did not end");
  a_count_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (vertical_sync_i && action_q == 3'b000 && running_q && !waiting_q && count_q < max_q)
    |=> count_q == $past(count_q) + 4'h1) else $error("count did not step");
  a_delay_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (vertical_sync_i && action_q == 3'b011) |=> waiting_q && wait_q == $past(delay_q))
    else $error("delay not loaded");
  a_idle_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (proto_q[1:0] == 2'b00) |=> $stable(gp_q[0])) else $error("idle signal moved");
  a_pin_hiz: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !pins_q[0] |=> gp_pin_oe_n_o[0]) else $error("pin driven while disabled");
  a_ext_blank: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pins_q[10] |=> gp_pin_oe_n_o[1] && horizontal_blanking_o == $past(gp_pin_in_i[1]))
    else $error("external blanking wrong");
  // A delayed count whose wait has run out must start counting from one.
  sequence s_wait_done;
    vertical_sync_i && action_q == 3'b000 && waiting_q && wait_q == 4'h0;
  endsequence
  sequence s_count_from_one;
    running_q && !waiting_q && count_q == 4'h1;
  endsequence
  a_delay_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_wait_done |=> s_count_from_one) else $error("delayed count did not start");
  a_manual_pol: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (vertical_sync_i && proto_q[1:0] == 2'b01) |=> gp_q[0] == $past(proto_q[6]))
    else $error("starting polarity not loaded");
  a_pin_toggle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pins_q[3:2] == 2'b00 && !proto_q[8]) |=> gp_pin_out_o[0] == $past(gp_q[0]))
    else $error("pin one not showing its signal");
  a_pin_lookup: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pins_q[3:2] == 2'b00 && proto_q[8]) |=> gp_pin_out_o[0] == $past(lut_bit[0]))
    else $error("pin one not showing lookup result");
  a_pin_fast: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pins_q[3:2] == 2'b11) |=> gp_pin_out_o[0] == $past(fast_timing_i[pins_q[7:6]]))
    else $error("pin one not showing fast timing");
endmodule

//--- fgo_pkg.sv
// Package with register map, field layouts and encodings of the field counted output generator.
package fgo_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] IDX_ACTION = 8'h50;
  localparam logic [7:0] IDX_LIMITS = 8'h51;
  localparam logic [7:0] IDX_PROTO  = 8'h52;
  localparam logic [7:0] IDX_PINS   = 8'h53;
  localparam logic [7:0] IDX_TOG0   = 8'h54;
  localparam logic [7:0] IDX_STATUS = 8'h5a;
  localparam int         NUM_TOG    = 4;
  // Limits register fields.
  localparam int MAX_LSB   = 0;
  localparam int DELAY_LSB = 4;
  // Protocol register fields.
  localparam int PROTO_LSB  = 0;
  localparam int LINE_LSB   = 4;
  localparam int POL_LSB    = 6;
  localparam int LUTEN_LSB  = 8;
  localparam int LUT_LSB    = 10;
  // Pin register fields.
  localparam int OE_LSB     = 0;
  localparam int SRC_LSB    = 2;
  localparam int HS_LSB     = 6;
  localparam int EXTBLK_LSB = 10;
  // Toggle register fields.
  localparam int TPIX_LSB   = 0;
  localparam int TLINE_LSB  = 13;
  localparam int TFLD_LSB   = 26;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0]  RESET_LUT  = 4'h6;

  typedef enum logic [2:0] {
    ACT_IDLE   = 3'b000,
    ACT_SINGLE = 3'b001,
    ACT_REPEAT = 3'b010,
    ACT_DELAY  = 3'b011,
    ACT_FORCE  = 3'b111
  } fgo_action_e;

  typedef enum logic [1:0] {
    PR_IDLE   = 2'b00,
    PR_MANUAL = 2'b01,
    PR_LINKED = 2'b10,
    PR_REPEAT = 2'b11
  } fgo_proto_e;

  typedef struct packed {
    logic [3:0]  field;
    logic [12:0] line;
    logic [12:0] pixel;
  } fgo_toggle_s;
endpackage

//--- fgo_pin_model.sv
// Model of the outside parts that sit on the two general purpose pins.
`timescale 1ns/1ns
module fgo_pin_model (
  input  wire logic       clk_i,    // Pixel clock.
  input  wire logic [1:0] out_i,    // Device pin levels.
  input  wire logic [1:0] oe_n_i,   // Device drive, low drives.
  input  wire logic       ext_en_i, // Outside part drives pin two.
  input  wire logic       ext_i,    // Level that it drives.
  output logic      [1:0] pin_o     // Resolved wire levels.
);
  logic [1:0] last_q = 2'b00;

  // A released pin that the outside part does not drive has no pull, so it shows the inverse of its last level.
  always_comb begin
    pin_o[0] = oe_n_i[0] ? ~last_q[0] : out_i[0];
    pin_o[1] = !oe_n_i[1] ? out_i[1] : (ext_en_i ? ext_i : ~last_q[1]);
  end

  always @(posedge clk_i) begin
    last_q <= pin_o;
  end
endmodule

//--- fgo_top_tb.sv
// Self-checking bench of the field counted output generator.
`timescale 1ns/1ns
module fgo_top_tb;
  localparam int LPIX = 40;
  localparam int FLEN = 160;
  localparam logic [15:0] LUTS = 16'he876;
  localparam logic [23:0] BAD = 24'h4f5bff;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        vs = 1'b0;
  logic        hs = 1'b0;
  logic        clp = 1'b0;
  logic        pbk = 1'b0;
  logic        hbi = 1'b0;
  logic        ext_en = 1'b0;
  logic        ext = 1'b0;
  logic        prdy, perr, rerr, hbo;
  logic [3:0]  fast = 4'h0;
  logic [3:0]  lut;
  logic [1:0]  pin, pout, poe_n, len, g;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] lfsr_q = 32'hc493df78;
  logic [31:0] prd, rdat, r;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          pc = 0;
  int          pend = 0, m_run = 0, m_wait = 0, m_cnt = 0, m_w = 0, m_max = 0, m_dly = 0;
  int          m_rep = 0, ex = 0;
  logic        eg;

  fgo_top DUT (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .pready_o(prdy), .prdata_o(prd),
    .pslverr_o(perr), .vertical_sync_i(vs), .hsync_i(hs), .black_clamp_pulse_i(clp),
    .preblank_pulse_i(pbk), .fast_timing_i(fast), .horizontal_blanking_int_i(hbi),
    .gp_pin_in_i(pin), .gp_pin_out_o(pout), .gp_pin_oe_n_o(poe_n), .horizontal_blanking_o(hbo));
  fgo_pin_model PARTNER (.clk_i(clk), .out_i(pout), .oe_n_i(poe_n), .ext_en_i(ext_en),
    .ext_i(ext), .pin_o(pin));

  always #4 clk = ~clk;

  // Fields of four short lines keep every counter scenario cheap.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pc <= (pc == FLEN - 1) ? 0 : pc + 1;
    vs <= (pc == FLEN - 1) && !rst;
    hs <= (pc % LPIX == LPIX - 1) && !rst;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd();
    lfsr_q = lfsr(lfsr_q);
    r = lfsr_q;
  endtask

  function automatic logic [31:0] msk(input int i);
    case (i)
      'h51: msk = 32'h0000_00ff;
      'h52: msk = 32'h0000_3fff;
      'h53: msk = 32'h0000_07ff;
      default: msk = 32'h3fff_ffff;
    endcase
  endfunction

  function automatic logic sel(input int s, input int h);
    return (s == 1) ? r[0] : (s == 2) ? (r[1] & ~r[0]) : r[2 + h];
  endfunction

  task automatic acc(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_vs();
    do @(posedge clk); while (vs !== 1'b1);
  endtask

  // Reference counter, stepped at every field start that the device sees.
  task automatic step();
    if (pend != 0) begin
      m_run = (pend == 1 || pend == 2);
      m_rep = (pend == 2);
      m_wait = (pend == 3);
      m_cnt = m_run;
      m_w = m_dly;
      pend = 0;
    end else if (m_wait != 0) begin
      m_run = (m_w == 0);
      m_wait = !m_run;
      m_cnt = m_run;
      m_w--;
    end else if (m_run != 0) begin
      m_run = m_rep || m_cnt < m_max;
      m_cnt = (m_cnt < m_max) ? m_cnt + 1 : m_run;
    end
  endtask

  task automatic count(input int act, input int mx, input int dly, input int nf);
    m_max = mx;
    m_dly = dly;
    acc(1'b1, 8'h51, 32'(dly * 16 + mx));
    wait_vs();
    step();
    cyc_n(20);
    acc(1'b1, 8'h50, 32'(act));
    pend = act;
    for (int f = 0; f < nf; f++) begin
      wait_vs();
      step();
      cyc_n(20);
      acc(1'b0, 8'h5a, 32'h0);
      chk(rdat & 32'hfc, 32'(m_run * 128 + m_wait * 64 + m_cnt * 4), "counter");
      acc(1'b0, 8'h50, 32'h0);
      chk(rdat, 32'h0, "action clear");
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk(32'(poe_n), 32'h3, "pins released");
    for (int i = 'h50; i < 'h58; i++) begin
      acc(1'b0, 8'(i), 32'h0);
      chk(rdat, (i == 'h52) ? 32'h1800 : 32'h0, "reset value");
    end
    for (int i = 'h51; i < 'h58; i++) begin
      rnd();
      acc(1'b1, 8'(i), r);
      acc(1'b0, 8'(i), 32'h0);
      chk(rdat, r & msk(i), "read back");
    end
    for (int k = 0; k < 3; k++) begin
      acc(1'b1, BAD[k*8 +: 8], 32'hffff_ffff);
      chk(32'(rerr), 32'h1, "unmapped error");
      acc(1'b0, BAD[k*8 +: 8], 32'h0);
      chk(rdat, 32'h0, "unmapped read");
    end
    acc(1'b1, 8'h52, 32'h0);
    acc(1'b1, 8'h53, 32'h0);
    count(0, 3, 0, 2);
    count(1, 15, 0, 17);
    count(2, 2, 0, 5);
    count(7, 2, 0, 2);
    count(3, 1, 2, 6);
    for (int s = 1; s < 4; s++) begin
      for (int h = 0; h < 4; h++) begin
        acc(1'b1, 8'h53, 32'(h * 64 + (3 - h) * 256 + s * 20 + 3));
        rnd();
        clp <= r[0];
        pbk <= r[1] & ~r[0];
        fast <= r[5:2];
        cyc_n(3);
        chk(32'(pout), 32'({sel(s, 3 - h), sel(s, h)}), "pin source");
        chk(32'(poe_n), 32'h0, "pin drive");
      end
    end
    acc(1'b1, 8'h53, 32'h0401);
    ext_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rnd();
      ext <= r[0];
      hbi <= r[1];
      if (i == 3) acc(1'b1, 8'h53, 32'h0001);
      cyc_n(3);
      chk(32'(hbo), 32'((i < 3) ? r[0] : r[1]), "blanking");
    end
    ext_en <= 1'b0;
    acc(1'b1, 8'h54, 32'h0400_400a);
    acc(1'b1, 8'h55, 32'h07ff_ffff);
    acc(1'b1, 8'h56, 32'h0400_2005);
    acc(1'b1, 8'h57, 32'h0400_6005);
    acc(1'b1, 8'h53, 32'h0003);
    // Signal one toggles once a field, or on all four lines; signal two twice.
    for (int i = 0; i < 4; i++) begin
      lut = LUTS[i*4 +: 4];
      len = 2'(i % 3 + 1);
      acc(1'b1, 8'h52, {18'h0, lut, len, 2'(i), (i == 3) ? 2'b01 : 2'b00, 4'h5});
      wait_vs();
      wait_vs();
      cyc_n(FLEN - 12);
      g = {i[1], i[0] ^ (i != 3)};
      chk(32'(pout), 32'({len[1] ? lut[g] : g[1], len[0] ? lut[g] : g[0]}), "lookup");
      acc(1'b0, 8'h5a, 32'h0);
      chk(32'(rdat[9:8]), 32'(g), "signal level");
    end
    // Field linked toggles: protocol two follows one single count, three every repetition.
    for (int m = 2; m < 4; m++) begin
      acc(1'b1, 8'h52, 32'h0);
      wait_vs();
      wait_vs();
      cyc_n(20);
      acc(1'b1, 8'h55, 32'h0800_400a);
      acc(1'b1, 8'h52, 32'(m));
      acc(1'b1, 8'h51, 32'h0000_0002);
      acc(1'b1, 8'h50, 32'(m - 1));
      for (int k = 1; k < 5; k++) begin
        wait_vs();
        cyc_n(FLEN - 12);
        ex = (m == 3) ? 2 - k % 2 : ((k < 3) ? k : 0);
        eg = g[0] ^ (k == 1 || (m == 3 && k == 3));
        chk(32'(pout[0]), 32'(eg), "linked pin");
        acc(1'b0, 8'h5a, 32'h0);
        chk(rdat & 32'h3fc, 32'({g[1], eg, ex != 0, 1'b0, 4'(ex), 2'b00}), "linked");
      end
    end
    end_sim();
  end
endmodule
